// ==== design/tcs_pkg.sv ====
package tcs_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] TCS_CMD_RESERVE = 8'hB4;
    localparam logic [7:0] TCS_CMD_RELEASE = 8'h94;
    localparam logic [7:0] TCS_CMD_SENSE = 8'h04;
    localparam logic [7:0] TCS_CMD_TEST_IO = 8'h00;
    localparam logic [7:0] TCS_CMD_NOOP = 8'h03;
    localparam logic [7:0] TCS_CMD_SET_MASK = 8'h1F;
    localparam logic [3:0] TCS_SENSE_GRP_NIB = 4'h4;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int TCS_NDEV = 16;
    localparam int TCS_NCH = 2;
    localparam logic [15:0] TCS_DEV_RST = 16'h0000;
    localparam logic [3:0] TCS_LOW_NIB_CUE = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TCS_SW_NEUTRAL,
        TCS_SW_A,
        TCS_SW_B
    } tcs_sw_t;

    typedef struct packed {
        logic sel;
        logic poll;
        logic sysrst;
        logic chain;
        logic stack;
        logic [7:0] cmd;
        logic [3:0] dev;
    } tcs_req_t;

    typedef struct packed {
        logic cu_busy;
        logic cu_end;
        logic busy;
        logic ch_end;
        logic dev_end;
        logic unit_check;
    } tcs_sts_t;

    typedef struct packed {
        logic valid;
        tcs_sts_t status;
        logic [7:0] addr;
    } tcs_resp_t;

    typedef struct packed {
        logic cmd_reject;
        logic invalid_seq;
    } tcs_sense_t;

endpackage

// ==== design/tcs_switch.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Switch holds neutral, A or B; neutral connects first channel completing selection.
// - After ending status return neutral unless chaining, stacked, unit check, or TIO/no-op during unit-check hold.
// - During unit-check hold, polling answered only for control-unit-end; stacked device-end waits.
// - After that hold, sense cleared by any sequence except TIO, sense, no-op.
// - Selection attempt while connected elsewhere gets short control-unit-busy answer.
// - Control-unit-busy and control-unit-end never share one status byte.
// - Short busy possible on every channel-initiated selection, any command.
// - After short busy, request-in and control-unit-end with base address once neutral.
// - Owed control-unit-end alone does not make unit busy to other channel.
// - Both request-in lines may be up in neutral; degated when connected elsewhere.
// - Sense-group commands other than sense, reserve, release rejected with command reject.
// - Reserve does sense functions and reserves device until release or system reset.
// - Reserve executes despite abnormal device conditions.
// - Reserve after set-file-mask in chain rejected with command reject, invalid sequence.
// - Without dual-channel option reserve rejected with command reject.
// - Release does sense functions and ends the device reservation.
// - Release executes despite abnormal device conditions.
// - Release after set-file-mask rejected invalid sequence; without option command reject.
// - Command to device busy or reserved elsewhere gets busy; device-end offered later.
// - System reset clears only the resetting channel's reservations and status.
module tcs_switch
    import tcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Channel requests, index 0 is A, 1 is B
    input wire tcs_req_t [TCS_NCH-1:0] req,
    input wire logic [TCS_NCH-1:0][3:0] base_addr,
    // Device side and option strap
    input wire logic [TCS_NDEV-1:0] dev_busy,
    input wire logic dual_opt,
    // Channel answers
    output tcs_resp_t [TCS_NCH-1:0] resp,
    output logic [TCS_NCH-1:0] req_in,
    // Unit state
    output tcs_sw_t sw_pos,
    output tcs_sense_t sense,
    output logic contingent
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tcs_sw_t sw;
        logic cont;
        logic sfm;
        tcs_sense_t sense;
        logic [TCS_NCH-1:0][TCS_NDEV-1:0] rsv;
        logic [TCS_NCH-1:0][TCS_NDEV-1:0] dep;
        logic [TCS_NCH-1:0] cue;
        tcs_resp_t [TCS_NCH-1:0] resp;
        logic [TCS_NCH-1:0] rin;
        logic [TCS_NDEV-1:0] busy_s1;
        logic [TCS_NDEV-1:0] busy_s2;
        logic opt_s1;
        logic opt_s2;
    } tcs_state_t;

    tcs_state_t st_r;
    tcs_state_t st_nxt;

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    function automatic tcs_sw_t conn_of(input int c);
        conn_of = (c == 0) ? TCS_SW_A : TCS_SW_B;
    endfunction

    function automatic logic is_tio_noop(input logic [7:0] cmd);
        is_tio_noop = (cmd == TCS_CMD_TEST_IO) || (cmd == TCS_CMD_NOOP);
    endfunction

    function automatic logic is_res_rel(input logic [7:0] cmd);
        is_res_rel = (cmd == TCS_CMD_RESERVE) || (cmd == TCS_CMD_RELEASE);
    endfunction

    function automatic logic is_sense_grp(input logic [7:0] cmd);
        is_sense_grp = (cmd[3:0] == TCS_SENSE_GRP_NIB);
    endfunction

    function automatic logic [4:0] first_set(input logic [TCS_NDEV-1:0] v);
        first_set = 5'h00;
        for (int i = TCS_NDEV - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = {1'b1, i[3:0]};
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        int o;
        logic [4:0] fs;
        logic [TCS_NDEV-1:0] ready;
        logic cont_prev;
        logic uc;
        logic stay;
        tcs_req_t r;
        o = 0;
        fs = 5'h00;
        ready = TCS_DEV_RST;
        cont_prev = 1'b0;
        uc = 1'b0;
        stay = 1'b0;
        r = '0;
        st_nxt = st_r;
        // Device busy lines and option strap, two flops each
        st_nxt.busy_s1 = dev_busy;
        st_nxt.busy_s2 = st_r.busy_s1;
        st_nxt.opt_s1 = dual_opt;
        st_nxt.opt_s2 = st_r.opt_s1;
        for (int c = 0; c < TCS_NCH; c++) begin
            st_nxt.resp[c] = '0;
        end
        // Channel A handled first, so in a tie B sees A connected if A's sequence stays connected
        for (int c = 0; c < TCS_NCH; c++) begin
            o = 1 - c;
            r = req[c];
            ready = st_nxt.dep[c] & ~st_r.busy_s2 & ~st_nxt.rsv[o];
            if (r.sysrst) begin
                // Only this channel's reservations and status go
                st_nxt.rsv[c] = TCS_DEV_RST;
                st_nxt.dep[c] = TCS_DEV_RST;
                st_nxt.cue[c] = 1'b0;
                if (st_nxt.sw == conn_of(c)) begin
                    st_nxt.sw = TCS_SW_NEUTRAL;
                    st_nxt.cont = 1'b0;
                    st_nxt.sfm = 1'b0;
                end
            end else if (r.sel && st_nxt.sw == conn_of(o)) begin
                // Short busy, never with control-unit-end
                st_nxt.resp[c].valid = 1'b1;
                st_nxt.resp[c].status.cu_busy = 1'b1;
                st_nxt.resp[c].addr = {base_addr[c], r.dev};
                st_nxt.cue[c] = 1'b1;
            end else if (r.sel) begin
                st_nxt.sw = conn_of(c);
                cont_prev = st_nxt.cont;
                uc = 1'b0;
                st_nxt.resp[c].valid = 1'b1;
                st_nxt.resp[c].addr = {base_addr[c], r.dev};
                if (!cont_prev && !is_tio_noop(r.cmd) && r.cmd != TCS_CMD_SENSE) begin
                    st_nxt.sense = '0;
                end
                if (is_sense_grp(r.cmd) && !is_res_rel(r.cmd)
                        && r.cmd != TCS_CMD_SENSE) begin
                    uc = 1'b1;
                    st_nxt.sense.cmd_reject = 1'b1;
                end else if (is_res_rel(r.cmd) && !st_r.opt_s2) begin
                    uc = 1'b1;
                    st_nxt.sense.cmd_reject = 1'b1;
                end else if (is_res_rel(r.cmd) && st_nxt.sfm) begin
                    uc = 1'b1;
                    st_nxt.sense.cmd_reject = 1'b1;
                    st_nxt.sense.invalid_seq = 1'b1;
                end else if (r.cmd == TCS_CMD_RESERVE && st_nxt.rsv[o][r.dev]) begin
                    st_nxt.resp[c].status.busy = 1'b1;
                    st_nxt.dep[c][r.dev] = 1'b1;
                end else if (is_res_rel(r.cmd)) begin
                    // Device busy or offline is not looked at here
                    st_nxt.rsv[c][r.dev] = (r.cmd == TCS_CMD_RESERVE);
                    st_nxt.resp[c].status.ch_end = 1'b1;
                    st_nxt.resp[c].status.dev_end = 1'b1;
                end else if (st_r.busy_s2[r.dev] || st_nxt.rsv[o][r.dev]) begin
                    st_nxt.resp[c].status.busy = 1'b1;
                    st_nxt.dep[c][r.dev] = 1'b1;
                end else begin
                    st_nxt.resp[c].status.ch_end = 1'b1;
                    st_nxt.resp[c].status.dev_end = 1'b1;
                end
                st_nxt.resp[c].status.unit_check = uc;
                if (uc) begin
                    st_nxt.cont = 1'b1;
                end else if (!is_tio_noop(r.cmd)) begin
                    st_nxt.cont = 1'b0;
                end
                if (r.cmd == TCS_CMD_SET_MASK) begin
                    st_nxt.sfm = 1'b1;
                end
                if (!r.chain) begin
                    st_nxt.sfm = 1'b0;
                end
                stay = r.chain || r.stack || uc || (cont_prev && is_tio_noop(r.cmd));
                if (!stay) begin
                    st_nxt.sw = TCS_SW_NEUTRAL;
                end
            end else if (r.poll && st_nxt.sw != conn_of(o)) begin
                fs = first_set(ready);
                if (st_nxt.cue[c]) begin
                    // Control-unit-end carries the base address
                    st_nxt.resp[c].valid = 1'b1;
                    st_nxt.resp[c].status.cu_end = 1'b1;
                    st_nxt.resp[c].addr = {base_addr[c], TCS_LOW_NIB_CUE};
                    st_nxt.cue[c] = r.stack;
                end else if (!st_nxt.cont && fs[4]) begin
                    st_nxt.resp[c].valid = 1'b1;
                    st_nxt.resp[c].status.dev_end = 1'b1;
                    st_nxt.resp[c].addr = {base_addr[c], fs[3:0]};
                    st_nxt.dep[c][fs[3:0]] = r.stack;
                end
            end
        end
        // Request-in from the settled next state
        for (int c = 0; c < TCS_NCH; c++) begin
            o = 1 - c;
            ready = st_nxt.dep[c] & ~st_r.busy_s2 & ~st_nxt.rsv[o];
            st_nxt.rin[c] = (st_nxt.sw != conn_of(o))
                && (st_nxt.cue[c] || (!st_nxt.cont && (|ready)));
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign resp = st_r.resp;
    assign req_in = st_r.rin;
    assign sw_pos = st_r.sw;
    assign sense = st_r.sense;
    assign contingent = st_r.cont;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_busy_no_cue: assert property (
        st_r.resp[0].status.cu_busy |-> !st_r.resp[0].status.cu_end
    ) else $error("busy and cu end together");

    chk_rin_degate: assert property (
        (st_r.sw == TCS_SW_B) |-> !st_r.rin[0]
    ) else $error("request-in A not degated");

    chk_short_busy: assert property (
        (ce && req[0].sel && !req[0].sysrst && st_r.sw == TCS_SW_B)
            |=> (st_r.resp[0].valid && st_r.resp[0].status.cu_busy)
    ) else $error("no short busy to A");

    chk_cue_owed: assert property (
        (ce && req[1].sel && !req[1].sysrst && !req[0].sysrst && st_r.sw == TCS_SW_A
            && !(req[0].sel && !req[0].chain && !req[0].stack))
            |=> st_r.cue[1]
    ) else $error("cu end not owed to B");

    chk_tie_a_wins: assert property (
        (ce && st_r.sw == TCS_SW_NEUTRAL && req[0].sel && req[1].sel
            && !req[0].sysrst && !req[1].sysrst)
            |=> (st_r.resp[0].valid && !st_r.resp[0].status.cu_busy)
    ) else $error("tie not given to A");

    chk_reserve_sets: assert property (
        (ce && req[0].sel && !req[0].sysrst && req[0].cmd == TCS_CMD_RESERVE && st_r.opt_s2
            && !st_r.sfm && st_r.sw != TCS_SW_B && !st_r.rsv[1][req[0].dev])
            |=> st_r.rsv[0][$past(req[0].dev)]
    ) else $error("reserve not taken");

    chk_nodual_reject: assert property (
        (ce && req[0].sel && !req[0].sysrst && is_res_rel(req[0].cmd) && !st_r.opt_s2
            && st_r.sw != TCS_SW_B)
            |=> (st_r.resp[0].status.unit_check && st_r.sense.cmd_reject && st_r.cont)
    ) else $error("option-less reserve not rejected");

    chk_sysrst_scope: assert property (
        (ce && req[0].sysrst && !req[1].sel && !req[1].sysrst)
            |=> (st_r.rsv[0] == TCS_DEV_RST && st_r.rsv[1] == $past(st_r.rsv[1]))
    ) else $error("system reset scope wrong");

    chk_sense_grp_rej: assert property (
        (ce && req[1].sel && !req[1].sysrst && is_sense_grp(req[1].cmd)
            && !is_res_rel(req[1].cmd) && req[1].cmd != TCS_CMD_SENSE
            && !(req[0].sel && !req[0].sysrst && (req[0].chain || req[0].stack))
            && st_r.sw != TCS_SW_A)
            |=> ##[0:1] st_r.sense.cmd_reject
    ) else $error("sense group not rejected");

    chk_busy_cue_b: assert property (
        st_r.resp[1].status.cu_busy |-> !st_r.resp[1].status.cu_end
    ) else $error("busy and cu end together on B");

    chk_rin_degate_b: assert property (
        (st_r.sw == TCS_SW_A) |-> !st_r.rin[1]
    ) else $error("request-in B not degated");

    chk_cont_connected: assert property (
        st_r.cont |-> (st_r.sw != TCS_SW_NEUTRAL)
    ) else $error("contingent hold without connection");

    chk_cont_poll_quiet: assert property (
        (ce && st_r.cont && st_r.sw == TCS_SW_A && req[0].poll && !req[0].sel
            && !req[0].sysrst && !st_r.cue[0])
            |=> !st_r.resp[0].valid
    ) else $error("poll answered during contingent hold");

    chk_sense_cleared: assert property (
        (ce && req[1].sel && !req[1].sysrst && st_r.sw == TCS_SW_NEUTRAL && !req[0].sel
            && !is_tio_noop(req[1].cmd) && !is_sense_grp(req[1].cmd))
            |=> (st_r.sense == '0)
    ) else $error("sense not cleared");

    chk_short_busy_b: assert property (
        (ce && req[1].sel && !req[1].sysrst && st_r.sw == TCS_SW_A && !req[0].sysrst
            && !(req[0].sel && !req[0].chain && !req[0].stack))
            |=> (st_r.resp[1].valid && st_r.resp[1].status.cu_busy)
    ) else $error("no short busy to B");

    chk_cue_rin: assert property (
        (st_r.sw == TCS_SW_NEUTRAL && st_r.cue[1]) |-> st_r.rin[1]
    ) else $error("owed cu end without request-in");

    chk_owed_not_busy: assert property (
        (ce && st_r.sw == TCS_SW_NEUTRAL && st_r.cue[1] && req[0].sel && !req[0].sysrst)
            |=> !st_r.resp[0].status.cu_busy
    ) else $error("owed cu end made unit busy");

    chk_release_clears: assert property (
        (ce && req[0].sel && !req[0].sysrst && req[0].cmd == TCS_CMD_RELEASE
            && st_r.opt_s2 && !st_r.sfm && st_r.sw != TCS_SW_B)
            |=> !st_r.rsv[0][$past(req[0].dev)]
    ) else $error("release not taken");

    cov_short_busy: cover property (
        st_r.resp[1].status.cu_busy ##[1:20] st_r.resp[1].status.cu_end);
    cov_both_rin: cover property (
        st_r.rin == 2'b11);
    cov_reserve_busy: cover property (
        st_r.resp[1].status.busy ##[1:50] st_r.resp[1].status.dev_end);
    cov_tie: cover property (
        st_r.sw == TCS_SW_NEUTRAL && req[0].sel && req[1].sel);
    cov_cont_end: cover property (
        st_r.cont ##1 !st_r.cont);

endmodule

// ==== tb/tcs_chan_model.sv ====
`timescale 1ns/1ps
module tcs_chan_model
    import tcs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bench request and poll control
    input wire tcs_req_t tb_req,
    input wire logic poll_en,
    input wire logic [3:0] poll_dly,
    // Unit side
    input wire logic req_in,
    output tcs_req_t req
);
    logic [4:0] cnt_r;

    // Waits poll_dly cycles on request-in, then polls once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (!req_in || !poll_en) begin
            cnt_r <= '0;
        end else if (cnt_r <= {1'b0, poll_dly}) begin
            cnt_r <= cnt_r + 5'h01;
        end
    end

    always_comb begin
        req = tb_req;
        if (!tb_req.sel && !tb_req.sysrst && req_in && poll_en && cnt_r == {1'b0, poll_dly}) begin
            req.poll = 1'b1;
        end
    end
endmodule

// ==== tb/two_channel_selection_switch_test.sv ====
`timescale 1ns/1ps
module two_channel_selection_switch_test;
    import tcs_pkg::*;

    localparam tcs_sts_t ST_ALL = 6'h3f;
    localparam tcs_sts_t ST_OK = 6'h06;
    localparam tcs_sts_t ST_UC = 6'h01;
    localparam tcs_sts_t M_UC = 6'h31;
    localparam tcs_sts_t ST_BSY = 6'h08;
    localparam tcs_sts_t M_BSY = 6'h38;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    tcs_req_t [1:0] tb_req = '0;
    tcs_req_t [1:0] req;
    logic [1:0][3:0] base_addr = {4'h9, 4'h5};
    logic [15:0] dev_busy = 16'h0000;
    logic dual_opt = 1'b1;
    logic [1:0] poll_en = 2'b00;
    logic [3:0] poll_dly = 4'h3;
    tcs_resp_t [1:0] resp;
    logic [1:0] req_in;
    tcs_sw_t sw_pos;
    tcs_sense_t sense;
    logic contingent;
    int mismatches = 0;
    int check_count = 0;

    always #12.5 clk = ~clk;

    tcs_switch dut (.clk(clk), .rst(rst), .ce(ce), .req(req), .base_addr(base_addr),
        .dev_busy(dev_busy), .dual_opt(dual_opt), .resp(resp), .req_in(req_in),
        .sw_pos(sw_pos), .sense(sense), .contingent(contingent));

    for (genvar c = 0; c < 2; c++) begin : g_ch
        tcs_chan_model chan (.clk(clk), .rst(rst), .tb_req(tb_req[c]), .poll_en(poll_en[c]),
            .poll_dly(poll_dly), .req_in(req_in[c]), .req(req[c]));
    end

    function automatic tcs_req_t mk(input logic [7:0] code, input logic [3:0] dv,
        input logic chain);
        tcs_req_t r;
        r = '0;
        r.sel = 1'b1;
        r.cmd = code;
        r.dev = dv;
        r.chain = chain;
        return r;
    endfunction

    function automatic tcs_req_t sr();
        tcs_req_t r;
        r = '0;
        r.sysrst = 1'b1;
        return r;
    endfunction

    function automatic logic [7:0] ad(input int c, input logic [3:0] dv);
        return {base_addr[c], dv};
    endfunction

    task automatic check_resp(input int c, input tcs_sts_t exp, input tcs_sts_t mask,
        input logic [7:0] exp_addr);
        check_count++;
        if (resp[c].valid !== 1'b1 || (resp[c].status & mask) !== exp
            || resp[c].addr !== exp_addr) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, resp[c], {1'b1, exp, exp_addr});
        end
    endtask

    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic send(input tcs_req_t ra, input tcs_req_t rb);
        @(posedge clk);
        tb_req <= {rb, ra};
        @(posedge clk);
        tb_req <= '0;
        @(negedge clk);
    endtask

    task automatic one(input int c, input tcs_req_t r);
        if (c == 0) begin
            send(r, '0);
        end else begin
            send('0, r);
        end
    endtask

    task automatic wait_poll(input int c);
        int n;
        n = 0;
        poll_en[c] <= 1'b1;
        @(negedge clk);
        while (resp[c].valid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        poll_en[c] <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        mismatches++;
        conclude();
    end

    initial begin
        logic [7:0] code;
        logic [3:0] dv;
        logic rej;
        void'($urandom(29));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        one(0, mk(TCS_CMD_RESERVE, 4'h3, 1'b0));
        check_resp(0, ST_OK, ST_ALL, ad(0, 4'h3));
        check_val(sw_pos, TCS_SW_NEUTRAL);
        one(1, sr());
        one(1, mk(TCS_CMD_SENSE, 4'h3, 1'b0));
        check_resp(1, ST_BSY, M_BSY, ad(1, 4'h3));
        one(0, mk(TCS_CMD_RELEASE, 4'h3, 1'b0));
        check_resp(0, ST_OK, ST_ALL, ad(0, 4'h3));
        wait_poll(1);
        check_resp(1, 6'h02, 6'h32, ad(1, 4'h3));
        one(0, mk(TCS_CMD_RESERVE, 4'h6, 1'b0));
        one(0, sr());
        one(1, mk(TCS_CMD_SENSE, 4'h6, 1'b0));
        check_resp(1, ST_OK, ST_ALL, ad(1, 4'h6));
        $display("test reserve done");
        @(posedge clk);
        dual_opt <= 1'b0;
        @(posedge clk);
        one(0, mk(TCS_CMD_RESERVE, 4'h2, 1'b0));
        check_resp(0, ST_UC, M_UC, ad(0, 4'h2));
        check_val({sense, contingent}, 8'h05);
        check_val(sw_pos, TCS_SW_A);
        one(1, mk(TCS_CMD_TEST_IO, 4'h2, 1'b0));
        check_resp(1, 6'h20, 6'h30, ad(1, 4'h2));
        one(0, mk(TCS_CMD_RELEASE, 4'h2, 1'b0));
        check_resp(0, ST_UC, M_UC, ad(0, 4'h2));
        one(0, mk(TCS_CMD_SENSE, 4'h2, 1'b0));
        check_val({sw_pos, contingent}, 8'h00);
        wait_poll(1);
        check_resp(1, 6'h10, 6'h30, ad(1, 4'h0));
        one(1, mk(8'h02, 4'h1, 1'b0));
        check_val(sense, 8'h00);
        @(posedge clk);
        dual_opt <= 1'b1;
        @(posedge clk);
        one(0, mk(TCS_CMD_SET_MASK, 4'h1, 1'b1));
        check_val(sw_pos, TCS_SW_A);
        one(0, mk(TCS_CMD_RESERVE, 4'h1, 1'b0));
        check_resp(0, ST_UC, M_UC, ad(0, 4'h1));
        check_val(sense, 8'h03);
        one(0, mk(TCS_CMD_SENSE, 4'h1, 1'b0));
        $display("test reject done");
        send(mk(8'h02, 4'h4, 1'b1), mk(8'h02, 4'h5, 1'b1));
        check_resp(0, ST_OK, ST_ALL, ad(0, 4'h4));
        check_resp(1, 6'h20, 6'h30, ad(1, 4'h5));
        check_val({sw_pos, req_in}, {TCS_SW_A, 2'b00});
        one(0, mk(8'h02, 4'h4, 1'b0));
        check_val({sw_pos, req_in}, {TCS_SW_NEUTRAL, 2'b10});
        one(0, mk(8'h02, 4'h7, 1'b0));
        check_resp(0, ST_OK, ST_ALL, ad(0, 4'h7));
        wait_poll(1);
        check_resp(1, 6'h10, 6'h30, ad(1, 4'h0));
        @(posedge clk);
        dev_busy <= 16'h0100;
        repeat (2) @(posedge clk);
        one(1, mk(8'h02, 4'h8, 1'b0));
        check_resp(1, ST_BSY, M_BSY, ad(1, 4'h8));
        @(posedge clk);
        dev_busy <= 16'h0000;
        wait_poll(1);
        check_resp(1, 6'h02, 6'h32, ad(1, 4'h8));
        $display("test short busy done");
        for (int i = 0; i < 40; i++) begin
            code = (i == 0) ? 8'hf4 : 8'($urandom);
            if (code inside {8'h00, 8'h03, 8'h1f, 8'h94, 8'hb4}) begin
                code = 8'h02;
            end
            rej = code[3:0] == 4'h4 && code != TCS_CMD_SENSE;
            dv = 4'($urandom);
            @(posedge clk);
            base_addr[0] <= 4'($urandom);
            one(0, mk(code, dv, 1'b0));
            check_resp(0, rej ? ST_UC : ST_OK, rej ? M_UC : ST_ALL, ad(0, dv));
            check_val(sw_pos, rej ? TCS_SW_A : TCS_SW_NEUTRAL);
        end
        $display("test random done");
        conclude();
    end
endmodule
